// file: logic/rsc_pkg.sv
// Constants, register map and encodings shared by the reset source control files.
// Assumes a 100 MHz core clock and a 32-bit APB register bus.
package rsc_pkg;

    localparam int CLK_PERIOD_NS = 10;

    // Minimum low-supply time, software-reset delay and reset pulse width, in ns
    localparam int MIN_LOW_SUPPLY_TIME_NS = 1000;
    localparam int SOFT_RESET_DELAY_NS    = 2000;
    localparam int RESET_PULSE_NS         = 40;

    // Least times round up to whole cycles, with no floor of one
    localparam int MIN_LOW_SUPPLY_CYC = (MIN_LOW_SUPPLY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SOFT_RESET_DLY_CYC = (SOFT_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_PULSE_CYC    = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 12;

    // Register byte offsets
    localparam logic [11:0] OFS_LEVEL_SELECT = 12'h000;
    localparam logic [11:0] OFS_CAUSE_FLAGS  = 12'h004;
    localparam logic [11:0] OFS_FLASH_CTRL1  = 12'h008;
    localparam logic [11:0] OFS_WAKE_STATUS  = 12'h00C;
    localparam logic [11:0] OFS_IRQ_STATUS   = 12'h010;
    localparam logic [11:0] OFS_IRQ_MASK     = 12'h014;

    // Level select codes
    localparam logic [7:0] LVL_1V70    = 8'h66;
    localparam logic [7:0] LVL_1V90    = 8'h55;
    localparam logic [7:0] LVL_2V55    = 8'h33;
    localparam logic [7:0] LVL_3V15    = 8'h99;
    localparam logic [7:0] LVL_3V80    = 8'hAA;
    localparam logic [7:0] LVL_DISABLE = 8'hF0;
    localparam logic [7:0] LEVEL_RESET = LVL_1V70;

    localparam logic [7:0] FLASH_RESET_KEY = 8'h55;

    // Reset cause flag bits
    localparam int CF_WDT_CTRL   = 0;
    localparam int CF_LEVEL_FLT  = 1;
    localparam int CF_SUPPLY_DRP = 2;
    localparam int CF_RST_CTRL   = 3;
    localparam int CF_W          = 4;

    // Wake status bits
    localparam int WS_EXPIRED = 0;
    localparam int WS_PWRDOWN = 1;

    // Interrupt event bits
    localparam int EV_SUPPLY_DROP = 0;
    localparam int EV_LEVEL_FAULT = 1;
    localparam int EV_FLASH_RESET = 2;
    localparam int EV_WDT_RUN     = 3;
    localparam int EV_WDT_SLEEP   = 4;
    localparam int EV_W           = 5;

    // Threshold selects driven to the comparator
    typedef enum logic [2:0] {
        RSC_THR_1V70 = 3'b000,
        RSC_THR_1V90 = 3'b001,
        RSC_THR_2V55 = 3'b010,
        RSC_THR_3V15 = 3'b011,
        RSC_THR_3V80 = 3'b100
    } rsc_thr_t;

endpackage : rsc_pkg

// file: logic/rsc_delay_counter.sv
// Saturating cycle counter that reports when a run condition has lasted a given count.
// Assumes run and clear are synchronous to core_clk.
`timescale 1ns/10ps
module rsc_delay_counter
    import rsc_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             resetn,
    input  wire logic             run,
    input  wire logic             clear,
    input  wire logic [CNT_W-1:0] limit,
    output logic                  expired
);

    logic [CNT_W-1:0] count;

    // Counts while run holds; restarts when run drops or on clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
        end else if (clear || !run) begin
            count <= '0;
        end else if (count != limit) begin
            count <= count + 1'b1;
        end
    end

    assign expired = run && !clear && (count == limit);

endmodule // rsc_delay_counter

// file: logic/rsc_reset_source_control.sv
// Reset source control: level select, cause flags, flash-key reset and watchdog resets.
// Assumes comparator, watchdog and sleep inputs synchronous to core_clk; resetn is power-on.
`timescale 1ns/10ps
// What this block does
// RULE_01: Codes 66h,55h,33h,99h,AAh select 1.7,1.9,2.55,3.15,3.8 volt thresholds.
// RULE_02: Code F0h disables the supply drop reset and is not a fault.
// RULE_03: Any other code causes full reset after the software-reset delay.
// RULE_04: Reset by an invalid code restores the level select register to 66h.
// RULE_05: Supply low must persist beyond the minimum time before reset fires.
// RULE_06: A genuine supply drop reset leaves the level select register unchanged.
// RULE_07: Cause flag bit 2 set on supply drop reset, cleared only by software.
// RULE_08: Cause flag bit 1 set on invalid code reset, cleared only by software.
// RULE_09: Cause flag bits seven to four read as zero.
// RULE_10: Writing 55h into flash control one resets the whole device.
// RULE_11: Watchdog expiry while running acts as supply drop reset and sets expired flag.
// RULE_12: Watchdog expiry asleep clears only PC and SP, sets expired and powerdown flags.
// RULE_13: Power-on clears expired and powerdown flags; pin or supply resets leave them.
// RULE_14: Power-on zeroes PC, disables interrupts, stops timers, inputs ports, SP top.
// RULE_15: Power-on clears watchdog and time base counters, then watchdog counts again.
// RULE_16: Supply drop reset is suspended during sleep or idle mode.
// RULE_17: Minimum low time and software-reset delay are parameterised cycle counters.
module rsc_reset_source_control
    import rsc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        supply_low,
    input  wire logic        sleep_mode,
    input  wire logic        wdt_timeout,
    output rsc_thr_t         threshold_sel,
    output logic             supply_monitor_en,
    output logic             system_reset,
    output logic             pc_sp_clear,
    output logic             core_defaults_load,
    output logic             wdt_tb_clear,
    output logic             irq
);

    logic [7:0]       low_voltage_level_select;
    logic [CF_W-1:0]  reset_cause_flags;
    logic             watchdog_expired_flag;
    logic             powerdown_flag;
    logic [EV_W-1:0]  irq_status;
    logic [EV_W-1:0]  irq_mask;
    logic [CNT_W-1:0] pulse_count;
    logic             por_active;
    logic             code_valid;
    logic             code_fault;
    logic             monitor_on;
    logic             low_expired;
    logic             fault_expired;
    logic             wr_en;
    logic             rd_en;
    logic             setup_rd;
    logic             addr_hit;
    logic             flash_key_hit;
    logic             wdt_run_hit;
    logic             wdt_sleep_hit;
    logic             fire_reset;
    logic [EV_W-1:0]  events;
    logic [31:0]      next_rdata;

    // Level select decode
    function automatic logic is_threshold(input logic [7:0] code);
        is_threshold = (code == LVL_1V70) || (code == LVL_1V90) || (code == LVL_2V55) ||
                       (code == LVL_3V15) || (code == LVL_3V80);
    endfunction

    function automatic logic is_mapped(input logic [11:0] addr);
        is_mapped = (addr == OFS_LEVEL_SELECT) || (addr == OFS_CAUSE_FLAGS) ||
                    (addr == OFS_FLASH_CTRL1) || (addr == OFS_WAKE_STATUS) ||
                    (addr == OFS_IRQ_STATUS) || (addr == OFS_IRQ_MASK);
    endfunction

    assign code_valid = is_threshold(low_voltage_level_select);
    assign code_fault = !code_valid && (low_voltage_level_select != LVL_DISABLE); // RULE_02
    assign monitor_on = code_valid && !sleep_mode;                                // RULE_16

    // APB slave, zero wait states
    assign pready   = 1'b1;
    assign addr_hit = is_mapped(paddr);
    assign pslverr  = psel && penable && !addr_hit;
    assign wr_en    = psel && penable && pwrite && addr_hit;
    assign rd_en    = psel && penable && !pwrite && addr_hit;
    assign setup_rd = psel && !penable && !pwrite;

    assign flash_key_hit = wr_en && (paddr == OFS_FLASH_CTRL1) && (pwdata[7:0] == FLASH_RESET_KEY); // RULE_10
    assign wdt_run_hit   = wdt_timeout && !sleep_mode;
    assign wdt_sleep_hit = wdt_timeout && sleep_mode;

    // Persistence and delay timers
    rsc_delay_counter u_low_timer (
        .core_clk (core_clk),
        .resetn   (resetn),
        .run      (monitor_on && supply_low),
        .clear    (system_reset),
        .limit    (CNT_W'(MIN_LOW_SUPPLY_CYC)),
        .expired  (low_expired)
    ); // RULE_05 RULE_17

    rsc_delay_counter u_fault_timer (
        .core_clk (core_clk),
        .resetn   (resetn),
        .run      (code_fault),
        .clear    (system_reset),
        .limit    (CNT_W'(SOFT_RESET_DLY_CYC)),
        .expired  (fault_expired)
    ); // RULE_03 RULE_17

    assign fire_reset = !system_reset && (low_expired || fault_expired || flash_key_hit || wdt_run_hit);

    // Full reset pulse generator
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pulse_count  <= '0;
            system_reset <= 1'b0;
        end else if (fire_reset) begin
            pulse_count  <= CNT_W'(RESET_PULSE_CYC - 1);
            system_reset <= 1'b1; // RULE_03 RULE_10 RULE_11
        end else if (pulse_count != '0) begin
            pulse_count <= pulse_count - 1'b1;
        end else begin
            system_reset <= 1'b0;
        end
    end

    // Power-on defaults, held through reset and one edge beyond
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            por_active <= 1'b1;
        end else begin
            por_active <= 1'b0;
        end
    end

    assign core_defaults_load = por_active;                  // RULE_14
    assign wdt_tb_clear       = por_active || system_reset;  // RULE_15

    // Warm clear of PC and SP on watchdog expiry while asleep
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pc_sp_clear <= 1'b0;
        end else begin
            pc_sp_clear <= wdt_sleep_hit; // RULE_12
        end
    end

    // Level select register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            low_voltage_level_select <= LEVEL_RESET;
        end else if (fire_reset && fault_expired) begin
            low_voltage_level_select <= LEVEL_RESET; // RULE_04
        end else if (wr_en && paddr == OFS_LEVEL_SELECT && !fire_reset) begin
            low_voltage_level_select <= pwdata[7:0]; // RULE_06
        end
    end

    // Threshold select and monitor enable to the comparator
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            threshold_sel     <= RSC_THR_1V70;
            supply_monitor_en <= 1'b0;
        end else begin
            supply_monitor_en <= monitor_on;
            unique case (low_voltage_level_select)
                LVL_1V90: threshold_sel <= RSC_THR_1V90; // RULE_01
                LVL_2V55: threshold_sel <= RSC_THR_2V55;
                LVL_3V15: threshold_sel <= RSC_THR_3V15;
                LVL_3V80: threshold_sel <= RSC_THR_3V80;
                default:  threshold_sel <= RSC_THR_1V70;
            endcase
        end
    end

    // Reset cause flags; hardware set wins over software write
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reset_cause_flags <= '0;
        end else begin
            reset_cause_flags <= ((wr_en && paddr == OFS_CAUSE_FLAGS) ? pwdata[CF_W-1:0] : reset_cause_flags)
                               | (CF_W'(fire_reset && (low_expired || wdt_run_hit)) << CF_SUPPLY_DRP) // RULE_07
                               | (CF_W'(fire_reset && fault_expired) << CF_LEVEL_FLT);               // RULE_08
        end
    end

    // Watchdog expired and powerdown flags
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            watchdog_expired_flag <= 1'b0; // RULE_13
            powerdown_flag        <= 1'b0;
        end else begin
            watchdog_expired_flag <= ((wr_en && paddr == OFS_WAKE_STATUS) ? pwdata[WS_EXPIRED] : watchdog_expired_flag)
                                   | wdt_timeout; // RULE_11 RULE_12
            powerdown_flag        <= ((wr_en && paddr == OFS_WAKE_STATUS) ? pwdata[WS_PWRDOWN] : powerdown_flag)
                                   | wdt_sleep_hit; // RULE_12
        end
    end

    // Interrupt status, cleared by read, set wins
    assign events = {wdt_sleep_hit, wdt_run_hit, flash_key_hit, fire_reset && fault_expired,
                     fire_reset && low_expired};

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irq_status <= '0;
        end else begin
            irq_status <= ((rd_en && paddr == OFS_IRQ_STATUS) ? '0 : irq_status) | events;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irq_mask <= '0;
        end else if (wr_en && paddr == OFS_IRQ_MASK) begin
            irq_mask <= pwdata[EV_W-1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // Read data captured in the setup cycle
    always_comb begin
        next_rdata = '0;
        unique case (paddr)
            OFS_LEVEL_SELECT: next_rdata[7:0] = low_voltage_level_select;
            OFS_CAUSE_FLAGS:  next_rdata[CF_W-1:0] = reset_cause_flags; // RULE_09
            OFS_WAKE_STATUS:  next_rdata[1:0] = {powerdown_flag, watchdog_expired_flag};
            OFS_IRQ_STATUS:   next_rdata[EV_W-1:0] = irq_status;
            OFS_IRQ_MASK:     next_rdata[EV_W-1:0] = irq_mask;
            default:          next_rdata = '0;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= '0;
        end else if (setup_rd) begin
            prdata <= next_rdata;
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    chk_flash_key_reset: assert property (flash_key_hit && !system_reset |=> system_reset) // RULE_10
        else $error("flash key write did not start a reset");
    chk_disable_no_fault: assert property ((low_voltage_level_select == LVL_DISABLE) |-> // RULE_02
                                           !fault_expired ##1 !supply_monitor_en)
        else $error("disable code treated as fault");
    chk_fault_restores: assert property (fire_reset && fault_expired |=> low_voltage_level_select == LEVEL_RESET
                                         && reset_cause_flags[CF_LEVEL_FLT]) // RULE_04 RULE_08
        else $error("invalid code reset did not restore register or set flag");
    chk_fault_delay: assert property ($rose(code_fault) && !system_reset |-> !system_reset [*8]) // RULE_03
        else $error("invalid code reset came too early");
    chk_fault_fires: assert property ($rose(code_fault) |-> ##[1:250] system_reset) // RULE_03
        else $error("invalid code reset never came");
    chk_supply_keeps_code: assert property (fire_reset && low_expired && !fault_expired |=>
                                            $stable(low_voltage_level_select)) // RULE_06
        else $error("supply drop reset changed level select");
    chk_supply_flag: assert property (fire_reset && low_expired |=> reset_cause_flags[CF_SUPPLY_DRP]) // RULE_07
        else $error("supply drop flag not set");
    chk_short_dip: assert property ($rose(supply_low) && monitor_on |-> !low_expired [*8]) // RULE_05
        else $error("short dip caused reset");
    chk_sleep_suspend: assert property (sleep_mode |-> !low_expired ##1 !supply_monitor_en) // RULE_16
        else $error("supply monitor active in sleep");
    chk_sleep_wdt: assert property (wdt_sleep_hit && !system_reset |=> pc_sp_clear && !system_reset
                                    && watchdog_expired_flag && powerdown_flag) // RULE_12
        else $error("sleep watchdog expiry handled wrongly");
    chk_run_wdt: assert property (wdt_run_hit && !system_reset |=> system_reset && watchdog_expired_flag) // RULE_11
        else $error("running watchdog expiry did not reset");
    chk_cause_upper_zero: assert property (rd_en && $past(setup_rd) && paddr == OFS_CAUSE_FLAGS
                                           |-> prdata[31:CF_W] == '0) // RULE_09
        else $error("cause flag upper bits not zero");
    chk_pulse_length: assert property ($rose(system_reset) |-> system_reset [*4] ##1 !system_reset) // RULE_10
        else $error("full reset pulse has the wrong length");
    chk_warm_clear_src: assert property (pc_sp_clear |-> $past(wdt_sleep_hit)) // RULE_12
        else $error("program counter clear without sleep watchdog expiry");
    chk_defaults_once: assert property (core_defaults_load |=> !core_defaults_load) // RULE_14
        else $error("core defaults held past power-on");
    chk_drop_flag_sticky: assert property (reset_cause_flags[CF_SUPPLY_DRP] && // RULE_07
                                           !(wr_en && paddr == OFS_CAUSE_FLAGS) |=> reset_cause_flags[CF_SUPPLY_DRP])
        else $error("supply drop flag cleared by hardware");
    chk_fault_flag_sticky: assert property (reset_cause_flags[CF_LEVEL_FLT] && // RULE_08
                                            !(wr_en && paddr == OFS_CAUSE_FLAGS) |=> reset_cause_flags[CF_LEVEL_FLT])
        else $error("level fault flag cleared by hardware");
    chk_kept_wake_flags: assert property (fire_reset && low_expired && !wdt_timeout // RULE_13
                                          && !(wr_en && paddr == OFS_WAKE_STATUS)
                                          |=> $stable({watchdog_expired_flag, powerdown_flag}))
        else $error("supply drop reset changed wake flags");
    chk_threshold_mid: assert property (low_voltage_level_select == LVL_2V55 |=> threshold_sel == RSC_THR_2V55) // RULE_01
        else $error("mid threshold code mapped wrongly");
    chk_threshold_top: assert property (low_voltage_level_select == LVL_3V80 |=> threshold_sel == RSC_THR_3V80) // RULE_01
        else $error("top threshold code mapped wrongly");

    cov_flash_reset:  cover property (flash_key_hit ##1 system_reset);
    cov_fault_reset:  cover property (fire_reset && fault_expired);
    cov_supply_reset: cover property (fire_reset && low_expired);
    cov_sleep_wdt:    cover property (wdt_sleep_hit ##1 pc_sp_clear);
    cov_run_wdt:      cover property (wdt_run_hit ##1 system_reset);

endmodule // rsc_reset_source_control

// file: tb/rsc_far_side.sv
// Partner model: supply comparator and watchdog counter beside the reset source block.
// Assumes the bench sets the supply in millivolts and gates the watchdog.
`timescale 1ns/10ps
module rsc_far_side
    import rsc_pkg::*;
#(
    parameter int WDT_LIMIT = 64
)(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [15:0] supply_mv,
    input  wire logic        wdt_en,
    input  wire rsc_thr_t    threshold_sel,
    input  wire logic        wdt_tb_clear,
    output logic             supply_low,
    output logic             wdt_timeout
);
    logic [15:0] thr_mv;
    logic [7:0]  wdt_cnt;

    // Threshold in millivolts for each select
    always_comb begin
        case (threshold_sel)
            RSC_THR_1V90: thr_mv = 16'h076C;
            RSC_THR_2V55: thr_mv = 16'h09F6;
            RSC_THR_3V15: thr_mv = 16'h0C4E;
            RSC_THR_3V80: thr_mv = 16'h0ED8;
            default:      thr_mv = 16'h06A4;
        endcase
    end

    assign supply_low = supply_mv < thr_mv;

    // Watchdog restarts from zero while cleared
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wdt_cnt     <= 8'h0;
            wdt_timeout <= 1'b0;
        end else begin
            wdt_timeout <= 1'b0;
            if (wdt_tb_clear || !wdt_en) begin
                wdt_cnt <= 8'h0;
            end else if (wdt_cnt == 8'(WDT_LIMIT - 1)) begin
                wdt_cnt     <= 8'h0;
                wdt_timeout <= 1'b1;
            end else begin
                wdt_cnt <= wdt_cnt + 8'h1;
            end
        end
    end
endmodule // rsc_far_side

// file: tb/testbench.sv
// Testbench for the reset source control block over APB.
// Assumes the partner model drives the comparator and watchdog inputs.
`timescale 1ns/10ps
module testbench
    import rsc_pkg::*;
;
    localparam int WDT_LIMIT = 64;
    localparam logic [7:0] CODES [5] = '{LVL_1V70, LVL_1V90, LVL_2V55, LVL_3V15, LVL_3V80};
    localparam rsc_thr_t   THRS  [5] = '{RSC_THR_1V70, RSC_THR_1V90, RSC_THR_2V55, RSC_THR_3V15, RSC_THR_3V80};
    logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        supply_low, sleep_mode, wdt_timeout, supply_monitor_en, system_reset;
    logic        pc_sp_clear, core_defaults_load, wdt_tb_clear, irq, wdt_en, err;
    rsc_thr_t    threshold_sel;
    logic [15:0] supply_mv;
    int          fail_count, n_tests, n, i;

    rsc_reset_source_control i_rsc_reset_source_control (.core_clk(core_clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .supply_low(supply_low), .sleep_mode(sleep_mode), .wdt_timeout(wdt_timeout),
        .threshold_sel(threshold_sel), .supply_monitor_en(supply_monitor_en), .system_reset(system_reset),
        .pc_sp_clear(pc_sp_clear), .core_defaults_load(core_defaults_load), .wdt_tb_clear(wdt_tb_clear),
        .irq(irq));
    rsc_far_side #(.WDT_LIMIT(WDT_LIMIT)) i_rsc_far_side (.core_clk(core_clk), .resetn(resetn),
        .supply_mv(supply_mv), .wdt_en(wdt_en), .threshold_sel(threshold_sel), .wdt_tb_clear(wdt_tb_clear),
        .supply_low(supply_low), .wdt_timeout(wdt_timeout));

    always #5 core_clk = ~core_clk;

    task automatic wrap_up();
        $display("mismatches %0d of %0d checks", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_range(input string what, input int lo, input int hi);
        n_tests++;
        if (n < lo || n > hi) begin
            fail_count++;
            $display("wrong value %s expected %0d to %0d seen %0d", what, lo, hi, n);
        end
    endtask

    // One APB transfer, then one idle cycle
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int k;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            fail_count++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk_word(what, exp, rd);
    endtask

    // Counts edges until the chosen reset output is seen, lim plus one if never
    task automatic wait_sig(input logic pcs, input int lim);
        for (n = 1; n <= lim; n++) begin
            @(posedge core_clk);
            if ((pcs ? pc_sp_clear : system_reset) === 1'b1) break;
        end
    endtask

    initial begin
        core_clk = 1'b0; resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h0; pwdata = 32'h0; sleep_mode = 1'b0; wdt_en = 1'b0; supply_mv = 16'h1388;
        fail_count = 0; n_tests = 0;
        repeat (11) @(posedge core_clk);
        chk_bit("defaults load", 1'b1, core_defaults_load);
        chk_bit("wdt clear", 1'b1, wdt_tb_clear);
        @(posedge core_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk_bit("defaults load", 1'b0, core_defaults_load);
        rchk(OFS_LEVEL_SELECT, 32'h66, "level select");
        rchk(OFS_CAUSE_FLAGS, 32'h0, "cause flags");
        rchk(OFS_WAKE_STATUS, 32'h0, "wake status");
        wr(OFS_CAUSE_FLAGS, 32'hFF);
        rchk(OFS_CAUSE_FLAGS, 32'hF, "cause flags");
        wr(OFS_CAUSE_FLAGS, 32'h0);
        for (i = 0; i < 5; i++) begin
            wr(OFS_LEVEL_SELECT, {24'h0, CODES[i]});
            repeat (2) @(posedge core_clk);
            chk_word("threshold", {29'h0, THRS[i]}, {29'h0, threshold_sel});
            chk_bit("monitor on", 1'b1, supply_monitor_en);
        end
        wr(OFS_LEVEL_SELECT, {24'h0, LVL_DISABLE});
        supply_mv <= 16'h03E8;
        wait_sig(1'b0, 250);
        chk_range("disabled reset", 251, 251);
        chk_bit("monitor off", 1'b0, supply_monitor_en);
        supply_mv <= 16'h1388;
        wr(OFS_LEVEL_SELECT, {24'h0, LVL_3V80});
        sleep_mode <= 1'b1;
        supply_mv  <= 16'h0CE4;
        wait_sig(1'b0, 150);
        chk_range("sleep supply reset", 151, 151);
        wdt_en <= 1'b1;
        wait_sig(1'b1, 100);
        chk_range("sleep wdt", WDT_LIMIT, WDT_LIMIT + 4);
        chk_bit("sleep full reset", 1'b0, system_reset);
        wdt_en     <= 1'b0;
        supply_mv  <= 16'h1388;
        sleep_mode <= 1'b0;
        rchk(OFS_WAKE_STATUS, 32'h3, "wake status");
        supply_mv <= 16'h0CE4;
        wait_sig(1'b0, 50);
        chk_range("short dip", 51, 51);
        supply_mv <= 16'h1388;
        repeat (2) @(posedge core_clk);
        supply_mv <= 16'h0CE4;
        wait_sig(1'b0, 300);
        chk_range("supply reset", MIN_LOW_SUPPLY_CYC, MIN_LOW_SUPPLY_CYC + 3);
        supply_mv <= 16'h1388;
        repeat (6) @(posedge core_clk);
        rchk(OFS_LEVEL_SELECT, 32'hAA, "level select");
        rchk(OFS_CAUSE_FLAGS, 32'h4, "cause flags");
        rchk(OFS_WAKE_STATUS, 32'h3, "wake status");
        wr(OFS_CAUSE_FLAGS, 32'h0);
        wr(OFS_WAKE_STATUS, 32'h0);
        rchk(OFS_CAUSE_FLAGS, 32'h0, "cause flags");
        wdt_en <= 1'b1;
        wait_sig(1'b0, 100);
        wdt_en <= 1'b0;
        chk_range("run wdt", WDT_LIMIT, WDT_LIMIT + 4);
        repeat (6) @(posedge core_clk);
        rchk(OFS_WAKE_STATUS, 32'h1, "wake status");
        rchk(OFS_CAUSE_FLAGS, 32'h4, "cause flags");
        wr(OFS_CAUSE_FLAGS, 32'h0);
        rchk(OFS_IRQ_STATUS, 32'h19, "irq status");
        wr(OFS_FLASH_CTRL1, {24'h0, FLASH_RESET_KEY});
        chk_bit("flash reset", 1'b1, system_reset);
        chk_bit("irq masked", 1'b0, irq);
        repeat (6) @(posedge core_clk);
        wr(OFS_IRQ_MASK, 32'h4);
        chk_bit("irq", 1'b1, irq);
        rchk(OFS_IRQ_STATUS, 32'h4, "irq status");
        chk_bit("irq cleared", 1'b0, irq);
        rchk(OFS_FLASH_CTRL1, 32'h0, "flash control");
        wr(OFS_IRQ_MASK, 32'h1F);
        wr(OFS_LEVEL_SELECT, 32'h12);
        wait_sig(1'b0, 400);
        chk_range("bad code reset", SOFT_RESET_DLY_CYC - 2, SOFT_RESET_DLY_CYC + 2);
        repeat (6) @(posedge core_clk);
        rchk(OFS_LEVEL_SELECT, 32'h66, "level select");
        rchk(OFS_CAUSE_FLAGS, 32'h2, "cause flags");
        chk_bit("irq", 1'b1, irq);
        rchk(OFS_IRQ_STATUS, 32'h2, "irq status");
        apb(1'b0, 12'h020, 32'h0);
        chk_bit("slave error", 1'b1, err);
        chk_word("unmapped read", 32'h0, rd);
        wrap_up();
    end
endmodule // testbench
